// File: rtl/rab_alarm_backup.sv
// Overview of operation
// - Bit 7 enables each alarm field compare.
// - Alarm field values held as BCD.
// - All-zero alarm register leaves field disabled.
// - Single alarm on match; outside pulse mode, at seconds rollover when seconds field disabled.
// - Match sets alarm0 flag, drives output low.
// - Pulse mode repeats output pulse per match.
// - Pulse mode sets flag each trigger, unattended.
// - Power-up default is standard switchover.
// - Standard: backup below lower of trip, battery.
// - Legacy: backup when supply below battery.
// - Select bit: 0 standard, 1 legacy.
// - Inhibit bit disables host bus in backup.
// - EEPROM access blocked in every backup mode.
// - Alarm output keeps working on battery.
// - Legacy battery still alarms; talks unless inhibit bit set.
// - Frequency output defaults to 32.768 kHz.
module rab_alarm_backup #(
    parameter int FOUT_HALF = rab_pkg::FOUT_HALF_CYCLES,
    parameter int PULSE_LEN = rab_pkg::PULSE_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic second_tick,
    input wire rab_pkg::rab_time_t now_time,
    input wire logic vdd_below_trip,
    input wire logic vdd_below_bat,
    output logic in_backup,
    output logic host_bus_enable,
    output logic eeprom_enable,
    output logic irq,
    output logic alarm_out_n_o,
    output logic alarm_out_n_oe,
    output logic fout
);
    import rab_pkg::*;

    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [7:0] alarm0 [NUM_FIELDS];
    logic [7:0] alarm_irq_control;
    logic [7:0] status;
    logic [7:0] irq_mask;
    logic [1:0] backup_control;
    rab_state_t state;
    logic [15:0] fout_count;
    logic [15:0] pulse_count;
    logic fout_level;
    logic [7:0] last_seconds;

    function automatic logic field_ok(input logic [7:0] a,
        input logic [7:0] t);
        field_ok = !a[FIELD_ENABLE_BIT] || (a[6:0] == t[6:0]);
    endfunction : field_ok

    function automatic logic sticky(input logic held, input logic clear,
        input logic set);
        sticky = (held && !clear) || set;
    endfunction : sticky

    // ****************************************************************
    // Bus decode.
    // ****************************************************************
    wire access = psel && penable && clk_en;
    wire wr = access && pwrite;
    wire rd_alarm = paddr < ADDR_ALARM_IRQ_CONTROL;
    wire [2:0] alarm_idx = paddr[4:2];
    wire wr_alarm = wr && rd_alarm && (paddr[1:0] == 2'h0);
    wire wr_ctrl = wr && (paddr == ADDR_ALARM_IRQ_CONTROL);
    wire wr_stat = wr && (paddr == ADDR_STATUS);
    wire wr_mask = wr && (paddr == ADDR_IRQ_MASK);
    wire wr_bkp = wr && (paddr == ADDR_BACKUP_CONTROL);
    wire mapped = (paddr[1:0] == 2'h0) && (paddr <= ADDR_BACKUP_CONTROL);

    // ****************************************************************
    // Backup selection.
    // ****************************************************************
    wire legacy = backup_control[SWITCHOVER_SELECT_BIT];
    wire inhibit = backup_control[BUS_INHIBIT_BIT];
    wire next_backup = legacy ? vdd_below_bat
        : (vdd_below_trip && vdd_below_bat);
    wire backup_entry = next_backup && !in_backup;

    // ****************************************************************
    // Alarm match.
    // ****************************************************************
    wire [7:0] fields [NUM_FIELDS];
    assign fields[0] = now_time.seconds;
    assign fields[1] = now_time.minutes;
    assign fields[2] = now_time.hours;
    assign fields[3] = now_time.date;
    assign fields[4] = now_time.month;
    assign fields[5] = now_time.weekday;
    logic all_match;
    always_comb
    begin
        all_match = 1'b1;
        for (int i = 0; i < NUM_FIELDS; i++)
        begin
            all_match = all_match && field_ok(alarm0[i], fields[i]);
        end
    end
    wire seconds_rolled = (last_seconds == SECONDS_ROLL)
        && (now_time.seconds == 8'h00);
    wire al_en = alarm_irq_control[ALARM0_ENABLE_BIT];
    wire pulse_mode = alarm_irq_control[PULSE_MODE_BIT];
    wire any_enabled = alarm0[0][7] | alarm0[1][7] | alarm0[2][7]
        | alarm0[3][7] | alarm0[4][7] | alarm0[5][7];
    wire sec_enabled = alarm0[0][FIELD_ENABLE_BIT];
    wire match_edge = second_tick && al_en && any_enabled && all_match
        && (pulse_mode || sec_enabled || seconds_rolled);
    wire clr_flag = wr_stat && pwdata[ALARM0_FLAG_BIT];
    wire clr_entry = wr_stat && pwdata[BACKUP_ENTER_BIT];
    wire [7:0] next_status = {6'h00,
        sticky(status[BACKUP_ENTER_BIT], clr_entry, backup_entry),
        sticky(status[ALARM0_FLAG_BIT], clr_flag, match_edge)};

    // ****************************************************************
    // Read selection.
    // ****************************************************************
    wire setup = psel && !penable;
    wire [7:0] status_view = {status[7:3], in_backup, status[1:0]};
    wire [7:0] alarm_view = (rd_alarm && mapped) ? alarm0[alarm_idx]
        : 8'h00;
    logic [7:0] read_byte;
    always_comb
    begin
        case (paddr)
            ADDR_ALARM_IRQ_CONTROL: read_byte = alarm_irq_control;
            ADDR_STATUS: read_byte = status_view;
            ADDR_IRQ_MASK: read_byte = irq_mask;
            ADDR_BACKUP_CONTROL: read_byte = {6'h00, backup_control};
            default: read_byte = alarm_view;
        endcase
    end
    wire [31:0] next_prdata = setup ? {24'h00_0000, read_byte} : 32'h0;

    // ****************************************************************
    // Writable registers.
    // ****************************************************************
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < NUM_FIELDS; i++)
            begin
                alarm0[i] <= ALARM_RESET;
            end
        end
        else if (wr_alarm)
        begin
            alarm0[alarm_idx] <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            alarm_irq_control <= CONTROL_RESET;
        end
        else if (wr_ctrl)
        begin
            alarm_irq_control <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_mask <= 8'h00;
        end
        else if (wr_mask)
        begin
            irq_mask <= pwdata[7:0] & STATUS_MASK;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            backup_control <= BACKUP_CONTROL_RESET;
        end
        else if (wr_bkp)
        begin
            backup_control <= pwdata[1:0];
        end
    end

    // ****************************************************************
    // Status and backup state.
    // ****************************************************************
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            status <= 8'h00;
        end
        else if (clk_en)
        begin
            status <= next_status;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            in_backup <= 1'b0;
        end
        else if (clk_en)
        begin
            in_backup <= next_backup;
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            last_seconds <= 8'h00;
        end
        else if (clk_en && second_tick)
        begin
            last_seconds <= now_time.seconds;
        end
    end

    // ****************************************************************
    // Alarm output state machine.
    // ****************************************************************
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= RAB_IDLE;
            pulse_count <= 16'h0000;
        end
        else if (clk_en)
        begin
            case (state)
                RAB_IDLE:
                begin
                    if (match_edge && pulse_mode)
                    begin
                        state <= RAB_PULSE;
                        pulse_count <= 16'(PULSE_LEN - 1);
                    end
                    else if (match_edge)
                    begin
                        state <= RAB_HELD;
                    end
                end
                RAB_HELD:
                begin
                    if (clr_flag && !match_edge)
                    begin
                        state <= RAB_IDLE;
                    end
                end
                RAB_PULSE:
                begin
                    if (pulse_count == 16'h0000)
                    begin
                        state <= RAB_IDLE;
                    end
                    else
                    begin
                        pulse_count <= pulse_count - 16'h0001;
                    end
                end
                default:
                begin
                    state <= RAB_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Frequency output.
    // ****************************************************************
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            fout_count <= 16'h0000;
            fout_level <= 1'b0;
        end
        else if (clk_en)
        begin
            if (fout_count == 16'(FOUT_HALF - 1))
            begin
                fout_count <= 16'h0000;
                fout_level <= !fout_level;
            end
            else
            begin
                fout_count <= fout_count + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            fout <= 1'b0;
        end
        else if (clk_en)
        begin
            fout <= fout_level;
        end
    end

    // ****************************************************************
    // Pin and interrupt outputs.
    // ****************************************************************
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            alarm_out_n_o <= 1'b0;
            alarm_out_n_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            alarm_out_n_o <= 1'b0;
            alarm_out_n_oe <= (state != RAB_IDLE);
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            irq <= |(next_status & irq_mask);
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            host_bus_enable <= 1'b1;
            eeprom_enable <= 1'b1;
        end
        else if (clk_en)
        begin
            host_bus_enable <= !(next_backup && inhibit);
            eeprom_enable <= !next_backup;
        end
    end

    // ****************************************************************
    // Bus answer.
    // ****************************************************************
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= next_prdata;
        end
    end

endmodule : rab_alarm_backup

// File: rtl/rab_pkg.sv
package rab_pkg;

    // ****************************************************************
    // Register map, byte addresses on the APB.
    // ****************************************************************
    localparam logic [7:0] ADDR_ALARM0_SECONDS = 8'h00;
    localparam logic [7:0] ADDR_ALARM0_MINUTES = 8'h04;
    localparam logic [7:0] ADDR_ALARM0_HOURS = 8'h08;
    localparam logic [7:0] ADDR_ALARM0_DATE = 8'h0c;
    localparam logic [7:0] ADDR_ALARM0_MONTH = 8'h10;
    localparam logic [7:0] ADDR_ALARM0_WEEKDAY = 8'h14;
    localparam logic [7:0] ADDR_ALARM_IRQ_CONTROL = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
    localparam logic [7:0] ADDR_BACKUP_CONTROL = 8'h24;

    // ****************************************************************
    // Field positions and reset values.
    // ****************************************************************
    localparam int FIELD_ENABLE_BIT = 7;
    localparam int ALARM0_ENABLE_BIT = 5;
    localparam int PULSE_MODE_BIT = 7;
    localparam int ALARM0_FLAG_BIT = 0;
    localparam int BACKUP_ENTER_BIT = 1;
    localparam int IN_BACKUP_BIT = 2;
    localparam int SWITCHOVER_SELECT_BIT = 0;
    localparam int BUS_INHIBIT_BIT = 1;
    localparam int NUM_FIELDS = 6;
    localparam logic [7:0] ALARM_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] BACKUP_CONTROL_RESET = 2'h0;
    localparam logic [7:0] STATUS_MASK = 8'h03;
    localparam logic [7:0] SECONDS_ROLL = 8'h59;

    // ****************************************************************
    // Timing.
    // ****************************************************************
    localparam int CLOCK_HZ = 200_000_000;
    localparam int FOUT_HZ = 32768;
    localparam int FOUT_HALF_CYCLES = CLOCK_HZ / (2 * FOUT_HZ);
    localparam int PULSE_NS = 20;
    localparam int PULSE_CYCLES = (PULSE_NS * CLOCK_HZ / 1_000_000
        + 999) / 1000;

    // ****************************************************************
    // Types.
    // ****************************************************************
    typedef struct packed {
        logic [7:0] weekday;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } rab_time_t;

    typedef enum logic [2:0] {
        RAB_IDLE = 3'b001,
        RAB_HELD = 3'b010,
        RAB_PULSE = 3'b100
    } rab_state_t;

endpackage : rab_pkg

// File: verif/rab_host.sv
module rab_host (
    input wire logic clock,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    int hangs = 0;
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            hangs++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : xfer
endmodule : rab_host

// File: verif/rab_props.sv
module rab_props (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic second_tick,
    input wire logic vdd_below_trip,
    input wire logic vdd_below_bat,
    input wire logic in_backup,
    input wire logic host_bus_enable,
    input wire logic eeprom_enable,
    input wire logic alarm_out_n_o,
    input wire logic alarm_out_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Checks.
    // ****
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_rdy;
        psel && !penable && clk_en |=> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_err;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err: assert property (p_err) else $error("stray error flag");
    property p_low;
        alarm_out_n_oe |-> !alarm_out_n_o;
    endproperty
    a_low: assert property (p_low) else $error("pin not low");
    property p_tick;
        $rose(alarm_out_n_oe) |-> $past(second_tick, 2);
    endproperty
    a_tick: assert property (p_tick) else $error("alarm off tick");
    property p_std;
        clk_en && vdd_below_trip && vdd_below_bat |=> ##[0:1] in_backup;
    endproperty
    a_std: assert property (p_std) else $error("no backup");
    property p_bat;
        (clk_en && !vdd_below_bat) [*2] |=> !in_backup;
    endproperty
    a_bat: assert property (p_bat) else $error("early backup");
    property p_eep;
        in_backup && $past(in_backup) |-> !eeprom_enable;
    endproperty
    a_eep: assert property (p_eep) else $error("eeprom open");
    property p_host;
        !in_backup && !$past(in_backup) |-> host_bus_enable && eeprom_enable;
    endproperty
    a_host: assert property (p_host) else $error("bus shut");
    property p_bus;
        !host_bus_enable |-> in_backup;
    endproperty
    a_bus: assert property (p_bus) else $error("bus shut early");
    c_alarm: cover property ($rose(alarm_out_n_oe));
    c_inhib: cover property (in_backup && !host_bus_enable);
    c_err: cover property (pslverr);
endmodule : rab_props

// File: verif/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rab_pkg::*;
    localparam int PL = 4;
    logic clock = 0, rstn = 0, clk_en = 1, second_tick = 0;
    logic vdd_below_trip = 0, vdd_below_bat = 0;
    rab_time_t now_time = '0;
    logic psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic in_backup, host_bus_enable, eeprom_enable, irq, oe, od, fo;
    int n_mismatch = 0, compares = 0, n, mdl[10];
    int rw[8] = '{0, 1, 2, 3, 4, 5, 6, 9};
    int cfg[2][7] = '{'{0, 'hb0, 'h91, 'h81, 'h81, 0, 'h20},
        '{'hb0, 0, 0, 0, 0, 0, 'ha0}};
    always #2.5 clock = ~clock;
    rab_alarm_backup #(.PULSE_LEN(PL)) rab_alarm_backup_inst (.clock,
        .rstn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .second_tick, .now_time, .vdd_below_trip,
        .vdd_below_bat, .in_backup, .host_bus_enable, .eeprom_enable, .irq,
        .alarm_out_n_o(od), .alarm_out_n_oe(oe), .fout(fo));
    rab_host rab_host_inst (.clock, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr);
    // ****
    // Helpers.
    // ****
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d);
        rab_host_inst.xfer(1'b1, a, d, rd, er);
        if (rab_host_inst.hangs != 0)
            tally_and_finish();
    endtask : wr
    task automatic rdc(logic [7:0] a, logic [31:0] e, string nm);
        rab_host_inst.xfer(1'b0, a, 32'h0, rd, er);
        if (rab_host_inst.hangs != 0)
            tally_and_finish();
        chk(nm, rd, e);
    endtask : rdc
    task automatic tick(rab_time_t t);
        now_time <= t;
        second_tick <= 1'b1;
        @(posedge clock);
        second_tick <= 1'b0;
        n = 0;
        repeat (16)
        begin
            @(negedge clock);
            n += int'(oe === 1'b1);
        end
        @(posedge clock);
    endtask : tick
    task automatic tally_and_finish;
        chk("hang", rab_host_inst.hangs, 0);
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    // ****
    // Sequence.
    // ****
    initial
    begin
        void'($urandom(32'ha0656813));
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 10; i++)
            rdc(8'(4 * i), mdl[i], "reset");
        foreach (rw[i])
        begin
            v = $urandom;
            wr(8'(4 * rw[i]), v);
            mdl[rw[i]] = int'(v & (rw[i] == 9 ? 32'h3 : 32'hff));
            rdc(8'(4 * rw[i]), mdl[rw[i]], "rw");
        end
        rdc(8'h28, 0, "unmapped");
        chk("slverr", er, 1);
        rdc(8'h01, 0, "unaligned");
        chk("slverr", er, 1);
        wr(ADDR_BACKUP_CONTROL, 0);
        for (int i = 0; i < 7; i++)
            wr(8'(4 * i), cfg[0][i]);
        tick(48'h030101112959);
        chk("oe", oe, 0);
        tick(48'h030101113000);
        chk("oe", oe, 1);
        rdc(ADDR_STATUS, 1, "status");
        wr(ADDR_IRQ_MASK, 1);
        @(posedge clock);
        chk("irq", irq, 1);
        tick(48'h030101113001);
        chk("oe", oe, 1);
        wr(ADDR_STATUS, 1);
        @(posedge clock);
        chk("oe", oe, 0);
        chk("irq", irq, 0);
        tick(48'h030201112959);
        tick(48'h030201113000);
        chk("oe", oe, 0);
        for (int i = 0; i < 7; i++)
            wr(8'(4 * i), cfg[1][i]);
        tick(48'h30);
        chk("pulse", n, PL);
        tick(48'h130);
        chk("pulse", n, PL);
        rdc(ADDR_STATUS, 1, "status");
        tick(48'h131);
        chk("pulse", n, 0);
        clk_en <= 1'b0;
        tick(48'h30);
        clk_en <= 1'b1;
        chk("frozen", n, 0);
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            v[0] = fo;
            while (fo === v[0] && n < 8000)
            begin
                @(negedge clock);
                n++;
            end
        end
        chk("fout", n, FOUT_HALF_CYCLES);
        @(posedge clock);
        for (int b = 0; b < 4; b++)
        begin
            wr(ADDR_BACKUP_CONTROL, b);
            vdd_below_bat <= 1'b1;
            repeat (3) @(posedge clock);
            chk("bkp", in_backup, b % 2);
            chk("ee", eeprom_enable, 1 - b % 2);
            chk("bus", host_bus_enable, int'(b != 3));
            vdd_below_trip <= 1'b1;
            repeat (3) @(posedge clock);
            chk("bkp", in_backup, 1);
            chk("ee", eeprom_enable, 0);
            chk("bus", host_bus_enable, int'(b < 2));
            tick(48'h30);
            chk("pulse", n, PL);
            {vdd_below_trip, vdd_below_bat} <= 2'b00;
            repeat (3) @(posedge clock);
            chk("bkp", in_backup, 0);
        end
        rdc(ADDR_STATUS, 3, "status");
        wr(ADDR_STATUS, 3);
        rdc(ADDR_STATUS, 0, "status");
        chk("irq", irq, 0);
        tally_and_finish();
    end
endmodule : testbench
bind rab_alarm_backup rab_props rab_props_inst (.clock, .rstn, .clk_en,
    .psel, .penable, .pready, .pslverr, .second_tick, .vdd_below_trip,
    .vdd_below_bat, .in_backup, .host_bus_enable, .eeprom_enable,
    .alarm_out_n_o, .alarm_out_n_oe);
